// file: src/dee_params.svh
/*
  Constants of the data EEPROM row programmer: bus addresses, control
  register layout, array geometry and programming cycle timing.
  Assumes a 100 MHz CPU clock and a 16-bit CPU address bus.
*/
`ifndef DEE_PARAMS_SVH
`define DEE_PARAMS_SVH

// Control/status register address
`define DEE_CSR_ADDR 16'h002C
// Array window: base and decode mask (256 bytes)
`define DEE_ARRAY_BASE 16'h0C00
`define DEE_ARRAY_MASK 16'hFF00
// Control/status reset value and bit positions
`define DEE_CSR_RESET 8'h00
`define DEE_BIT_IE 2
`define DEE_BIT_LAT 1
`define DEE_BIT_PGM 0
// Geometry: 16 rows of 16 bytes
`define DEE_COLS 16
`define DEE_COL_W 4
`define DEE_ROW_W 4
// Timing of one programming cycle
`define DEE_CLK_MHZ 100
`define DEE_PROG_TIME_NS 2000
`define DEE_PROG_CYCLES ((`DEE_PROG_TIME_NS * `DEE_CLK_MHZ + 999) / 1000)
`define DEE_CNT_W 16

`endif

// file: src/dee_pkg.sv
/*
  Types of the data EEPROM row programmer.
  Assumes dee_params.svh is included by the modules that need numbers.
*/
package dee_pkg;

  // Controller states, one-hot
  typedef enum logic [3:0] {
    DEE_ST_IDLE = 4'h1,
    DEE_ST_PROG = 4'h2,
    DEE_ST_WAIT = 4'h4,
    DEE_ST_HALT = 4'h8
  } dee_state_t;

  // One data byte
  typedef logic [7:0] dee_byte_t;

endpackage

// file: src/dee_array.sv
/*
  Cell array of the data EEPROM: 256 bytes, one read port, one row wide
  program port with a byte mask.
  Assumes the controller keeps the program strobe to one cycle.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dee_params.svh"

module dee_array (
  input wire logic clock,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic prog_we,
  input wire logic [`DEE_ROW_W-1:0] prog_row,
  input wire logic [8*`DEE_COLS-1:0] prog_data,
  input wire logic [`DEE_COLS-1:0] prog_mask
);

  // Cells; no reset, content is nonvolatile by intent
  logic [7:0] cell_ff [0:255];

  // Asynchronous read, the controller registers it
  assign rd_data = cell_ff[rd_addr];

  // Erase and program every latched byte of the row at once
  always_ff @(posedge clock)
  begin
    if (prog_we)
    begin
      for (int c = 0; c < `DEE_COLS; c++)
      begin
        if (prog_mask[c])
        begin
          cell_ff[{prog_row, c[`DEE_COL_W-1:0]}] <= prog_data[8*c +: 8];
        end
      end
    end
  end

endmodule
`default_nettype wire

// file: src/dee_ctrl.sv
/*
  Data EEPROM row programmer: bus decode, control/status register,
  sixteen write latches, programming timer, interrupt request and
  wait/halt handling. Instantiates the cell array.
  Assumes the CPU gives single-cycle read/write strobes synchronous to
  clock, and pulses for vector fetch, wait, halt and wake-up.
// Notes on behaviour
// - Read mode returns array byte next cycle
// - Write mode captures writes into sixteen latches
// - Program start burns all captured latches together
// - Target row comes from last captured write
// - Cycle end clears start, latch mode; interrupt
// - Vector fetch withdraws pending interrupt request
// - Latches clear at end/mode fall; AND merge
// - Latch contents can never be read back
// - Wait entered now, or after running cycle
// - Halt stops at once, abandoning the cycle
// - Array read in write mode leaves bus undriven
// - Array write in read mode is ignored
// - Control bits seven to three read zero
// - Bit two enables end-of-cycle interrupt
// - Mode bit cleared by software only when idle
// - Bit zero starts cycle, reads busy
// - Cycle duration timed entirely inside the block
*/
`timescale 1ns/10ps
`default_nettype none
`include "dee_params.svh"

module dee_ctrl #(
  parameter int unsigned PROG_CYCLES = `DEE_PROG_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  output logic bus_rdata_oe,
  input wire logic vector_fetch,
  input wire logic wfi_exec,
  input wire logic halt_exec,
  input wire logic wake,
  output logic irq,
  output logic wait_mode,
  output logic halt_mode
);

  // Array window decode, shared by read and write paths
  function automatic logic in_array(input logic [15:0] a);
    return (a & `DEE_ARRAY_MASK) == `DEE_ARRAY_BASE;
  endfunction

  // Every check runs on the one clock and sleeps through reset
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  dee_pkg::dee_state_t st_ff; // Controller state
  logic ie_ff; // Interrupt enable
  logic lat_ff; // Write-latch mode
  logic pgm_ff; // Program start / busy
  logic irq_ff; // Pending request
  logic wfi_pend_ff; // Wait asked during a cycle
  logic [`DEE_CNT_W-1:0] cnt_ff; // Cycles left in the cycle
  logic [`DEE_ROW_W-1:0] row_ff; // Target row
  logic [7:0] lat_data_ff [0:`DEE_COLS-1]; // Latched bytes
  logic [`DEE_COLS-1:0] lat_valid_ff; // Latch holds a byte
  logic [8*`DEE_COLS-1:0] lat_flat; // Latches for the array port
  logic [7:0] arr_q; // Array read data
  logic [7:0] rdata_ff; // Registered read data
  logic rdata_oe_ff; // Registered drive enable

  logic csr_hit; // Register address match
  logic arr_hit; // Array address match
  logic csr_wr; // Register write strobe
  logic arr_wr; // Array write strobe
  logic cap; // Write taken into a latch
  logic start; // Cycle begins
  logic done; // Cycle ends normally
  logic abort; // Cycle abandoned
  logic lat_clr; // Latches emptied
  logic lat_fall; // Software drops write mode
  logic [`DEE_COL_W-1:0] col; // Latch column of this write

  assign csr_hit = bus_addr == `DEE_CSR_ADDR;
  assign arr_hit = in_array(bus_addr);
  assign csr_wr = bus_wr && csr_hit;
  assign arr_wr = bus_wr && arr_hit;
  assign col = bus_addr[`DEE_COL_W-1:0];
  // capture only in write mode, idle
  assign cap = arr_wr && lat_ff && !pgm_ff && (st_ff == dee_pkg::DEE_ST_IDLE);
  // software write of one starts a cycle
  assign start = csr_wr && bus_wdata[`DEE_BIT_PGM] && !pgm_ff
    && (lat_ff || bus_wdata[`DEE_BIT_LAT]) && !halt_exec
    && (st_ff == dee_pkg::DEE_ST_IDLE);
  // end of cycle comes from the internal timer only
  assign done = (st_ff == dee_pkg::DEE_ST_PROG) && (cnt_ff == '0)
    && !halt_exec && !abort;
  // Clearing start mid-cycle abandons it; the row is not programmed
  assign abort = (st_ff == dee_pkg::DEE_ST_PROG) && csr_wr
    && !bus_wdata[`DEE_BIT_PGM];
  assign lat_fall = csr_wr && !bus_wdata[`DEE_BIT_LAT] && !pgm_ff && lat_ff;
  // only cycle end or a falling mode bit empties them
  assign lat_clr = done || lat_fall;

  // State sequencing
  always_ff @(posedge clock)
  begin
    if (rst)
      st_ff <= dee_pkg::DEE_ST_IDLE;
    else
      unique case (st_ff)
        dee_pkg::DEE_ST_IDLE:
          if (halt_exec)
            st_ff <= dee_pkg::DEE_ST_HALT;
          else if (start)
            st_ff <= dee_pkg::DEE_ST_PROG;
          else if (wfi_exec)
            st_ff <= dee_pkg::DEE_ST_WAIT;
        dee_pkg::DEE_ST_PROG:
          if (halt_exec)
            st_ff <= dee_pkg::DEE_ST_HALT;
          else if (done && (wfi_pend_ff || wfi_exec))
            st_ff <= dee_pkg::DEE_ST_WAIT;
          else if (done || abort)
            st_ff <= dee_pkg::DEE_ST_IDLE;
        dee_pkg::DEE_ST_WAIT:
          if (halt_exec)
            st_ff <= dee_pkg::DEE_ST_HALT;
          else if (wake)
            st_ff <= dee_pkg::DEE_ST_IDLE;
        dee_pkg::DEE_ST_HALT:
          if (wake)
            st_ff <= dee_pkg::DEE_ST_IDLE;
        // Not one-hot: recover to idle
        default:
          st_ff <= dee_pkg::DEE_ST_IDLE;
      endcase
  end

  // Wait request remembered while a cycle runs
  always_ff @(posedge clock)
  begin
    if (rst || st_ff != dee_pkg::DEE_ST_PROG)
      wfi_pend_ff <= 1'b0;
    else if (wfi_exec)
      wfi_pend_ff <= 1'b1;
  end

  // Programming timer; frozen value is irrelevant outside a cycle
  always_ff @(posedge clock)
  begin
    if (rst)
      cnt_ff <= '0;
    // load the configured length at start
    else if (start)
      cnt_ff <= `DEE_CNT_W'(PROG_CYCLES - 1);
    else if (st_ff == dee_pkg::DEE_ST_PROG && cnt_ff != '0)
      cnt_ff <= cnt_ff - `DEE_CNT_W'(1);
  end

  // Interrupt enable, plain software bit
  always_ff @(posedge clock)
  begin
    if (rst)
      ie_ff <= 1'(`DEE_CSR_RESET >> `DEE_BIT_IE);
    else if (csr_wr)
      ie_ff <= bus_wdata[`DEE_BIT_IE];
  end

  // Write-latch mode bit
  always_ff @(posedge clock)
  begin
    if (rst)
      lat_ff <= 1'b0;
    else if (done)
      lat_ff <= 1'b0;
    // set any time, clear only when not busy
    else if (csr_wr && bus_wdata[`DEE_BIT_LAT])
      lat_ff <= 1'b1;
    else if (lat_fall)
      lat_ff <= 1'b0;
  end

  // Program start / busy bit
  always_ff @(posedge clock)
  begin
    if (rst)
      pgm_ff <= 1'b0;
    // cleared at cycle end or abort; halt abandons
    else if (done || abort || halt_exec)
      pgm_ff <= 1'b0;
    else if (start)
      pgm_ff <= 1'b1;
  end

  // Interrupt request; a new end event beats the vector fetch
  always_ff @(posedge clock)
  begin
    if (rst)
      irq_ff <= 1'b0;
    else if (done && ie_ff)
      irq_ff <= 1'b1;
    else if (vector_fetch)
      irq_ff <= 1'b0;
  end

  // Target row follows the latest captured write
  always_ff @(posedge clock)
  begin
    if (rst)
      row_ff <= '0;
    // upper bits of last captured write
    else if (cap)
      row_ff <= bus_addr[`DEE_COL_W +: `DEE_ROW_W];
  end

  // One latch per column
  genvar gc;
  generate
    for (gc = 0; gc < `DEE_COLS; gc++)
    begin : g_lat
      always_ff @(posedge clock)
      begin
        if (rst || lat_clr)
        begin
          lat_valid_ff[gc] <= 1'b0;
          lat_data_ff[gc] <= 8'hFF;
        end
        else if (cap && col == `DEE_COL_W'(gc))
        begin
          lat_valid_ff[gc] <= 1'b1;
          lat_data_ff[gc] <= lat_data_ff[gc] & bus_wdata;
        end
      end
      assign lat_flat[8*gc +: 8] = lat_data_ff[gc];
      // Repeated writes merge by AND
      and_merge_a: assert property (cap && col == `DEE_COL_W'(gc)
        |=> lat_data_ff[gc] == ($past(lat_data_ff[gc]) & $past(bus_wdata)))
        else $error("latch did not AND merge");
    end
  endgenerate

  // all valid latches written in the one end strobe
  dee_array u_array (
    .clock(clock),
    .rd_addr(bus_addr[7:0]),
    .rd_data(arr_q),
    .prog_we(done),
    .prog_row(row_ff),
    .prog_data(lat_flat),
    .prog_mask(lat_valid_ff)
  );

  // Read path; latches never reach the bus
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rdata_ff <= 8'h00;
      rdata_oe_ff <= 1'b0;
    end
    else if (bus_rd && csr_hit)
    begin
      rdata_ff <= {5'h00, ie_ff, lat_ff, pgm_ff};
      rdata_oe_ff <= 1'b1;
    end
    else if (bus_rd && arr_hit && !lat_ff)
    begin
      rdata_ff <= arr_q;
      rdata_oe_ff <= 1'b1;
    end
    else
    begin
      // write mode read leaves bus undriven; no readback
      rdata_ff <= 8'h00;
      rdata_oe_ff <= 1'b0;
    end
  end

  assign bus_rdata = rdata_ff;
  assign bus_rdata_oe = rdata_oe_ff;
  assign irq = irq_ff;
  // One-hot state bits leave the block straight from the flop
  assign wait_mode = st_ff[2];
  assign halt_mode = st_ff[3];

  csr_rsvd_a: assert property ($past(bus_rd && csr_hit)
    |-> bus_rdata_oe && bus_rdata[7:3] == 5'h00)
    else $error("reserved bits not zero");
  rd_rom_a: assert property (bus_rd && arr_hit && !csr_hit && !lat_ff
    |=> bus_rdata_oe && bus_rdata == $past(arr_q))
    else $error("array read data wrong");
  rd_undriven_a: assert property (bus_rd && arr_hit && !csr_hit && lat_ff
    |=> !bus_rdata_oe)
    else $error("bus driven in write mode");
  prog_len_a: assert property (start |=> pgm_ff
    && cnt_ff == `DEE_CNT_W'(PROG_CYCLES - 1))
    else $error("cycle length not loaded");
  end_clear_a: assert property (done |=> !pgm_ff && !lat_ff
    && lat_valid_ff == '0)
    else $error("end of cycle did not clear");
  irq_set_a: assert property (done && ie_ff |=> irq ##1 (irq ||
    $past(vector_fetch)))
    else $error("interrupt not raised");
  irq_vec_a: assert property (vector_fetch && !(done && ie_ff)
    |=> !irq)
    else $error("interrupt not withdrawn");
  lat_ignore_a: assert property (arr_wr && !lat_ff
    |=> $stable(lat_valid_ff))
    else $error("latch took write in read mode");
  wait_idle_a: assert property (wfi_exec && !halt_exec && !start
    && st_ff == dee_pkg::DEE_ST_IDLE |=> wait_mode)
    else $error("wait not entered");
  halt_stop_a: assert property (halt_exec |=> halt_mode && !pgm_ff)
    else $error("halt did not stop");
  lat_hold_a: assert property (pgm_ff && lat_ff && csr_wr && !done
    && !bus_wdata[`DEE_BIT_LAT] |=> lat_ff)
    else $error("mode bit cleared while busy");

endmodule
`default_nettype wire

// file: tb/dee_cpu_model.sv
/*
  CPU side of the memory bus for the data EEPROM row programmer.
  Assumes strobes are taken on the rising clock edge, one cycle each.
*/
`timescale 1ns/10ps
`default_nettype none

module dee_cpu_model (
  input wire logic clock,
  output logic [15:0] bus_addr,
  output logic bus_rd,
  output logic bus_wr,
  output logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata,
  input wire logic bus_rdata_oe,
  output logic vector_fetch,
  output logic wfi_exec,
  output logic halt_exec,
  output logic wake
);
  // Quiet bus from time zero
  initial
  begin
    bus_addr = 16'h0000;
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    bus_wdata = 8'h00;
    vector_fetch = 1'b0;
    wfi_exec = 1'b0;
    halt_exec = 1'b0;
    wake = 1'b0;
  end

  // One write, strobe held across exactly one taking edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(posedge clock);
    #1;
    bus_wr = 1'b0;
    // Released data shows the inverse, never a stale copy
    bus_wdata = ~d;
  endtask

  // data reads only, never a code fetch
  task automatic rd(input logic [15:0] a, output logic [7:0] d,
                    output logic oe);
    @(posedge clock);
    #1;
    bus_addr = a;
    bus_rd = 1'b1;
    @(posedge clock);
    #1;
    bus_rd = 1'b0;
    // Answer stands one cycle: take it now
    d = bus_rdata;
    oe = bus_rdata_oe;
  endtask

  // Core event pulse: 8 vector, 4 wait, 2 halt, 1 wake
  task automatic pulse(input logic [3:0] sel);
    @(posedge clock);
    #1;
    vector_fetch = sel[3];
    wfi_exec = sel[2];
    halt_exec = sel[1];
    wake = sel[0];
    @(posedge clock);
    #1;
    vector_fetch = 1'b0;
    wfi_exec = 1'b0;
    halt_exec = 1'b0;
    wake = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
/*
  Self-checking bench of the data EEPROM row programmer, compared with
  a model of array, latches and control bits kept in integers.
  Assumes dee_cpu_model as bus partner and a short cycle count.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dee_params.svh"

module tb_top;
  // Short programming cycle keeps the run brief
  localparam int PC = 8;
  localparam logic [15:0] CSR = `DEE_CSR_ADDR;
  logic clock;
  logic rst;
  logic [15:0] bus_addr;
  logic bus_rd, bus_wr, bus_rdata_oe;
  logic [7:0] bus_wdata, bus_rdata, rd_d;
  logic vector_fetch, wfi_exec, halt_exec, wake;
  logic irq, wait_mode, halt_mode, rd_oe, m_ie, m_lat;
  // Model: array bytes and latches, -1 meaning unknown or empty
  int mem [256] = '{default: -1};
  int latv [16] = '{default: -1};
  int row;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] rs = 32'd71377;

  dee_ctrl #(.PROG_CYCLES(PC)) uut (.clock(clock), .rst(rst),
    .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_rdata_oe(bus_rdata_oe), .vector_fetch(vector_fetch),
    .wfi_exec(wfi_exec), .halt_exec(halt_exec), .wake(wake),
    .irq(irq), .wait_mode(wait_mode), .halt_mode(halt_mode));

  dee_cpu_model cpu (.clock(clock), .bus_addr(bus_addr),
    .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .bus_rdata_oe(bus_rdata_oe),
    .vector_fetch(vector_fetch), .wfi_exec(wfi_exec),
    .halt_exec(halt_exec), .wake(wake));

  // 100 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Hang guard, far above the two hundred or so cycles needed
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_mismatch++;
      results();
    end
  end

  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Xorshift source for data bytes
  function automatic logic [7:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction

  // Control write, mirrored in the model
  task automatic csr_wr(input logic [7:0] d);
    cpu.wr(CSR, d);
    m_ie = d[2];
    if (m_lat && !d[1])
      latv = '{default: -1};
    m_lat = d[1];
  endtask

  task automatic chk_csr(input logic [7:0] e);
    cpu.rd(CSR, rd_d, rd_oe);
    check(rd_d, e);
  endtask

  // Array write; only write mode fills a latch
  task automatic aw(input logic [7:0] a, input logic [7:0] d);
    cpu.wr(`DEE_ARRAY_BASE | 16'(a), d);
    if (m_lat)
    begin
      latv[a[3:0]] = (latv[a[3:0]] < 0) ? int'(d) : latv[a[3:0]] & d;
      row = a[7:4];
    end
  endtask

  task automatic chk_arr(input logic [7:0] a);
    cpu.rd(`DEE_ARRAY_BASE | 16'(a), rd_d, rd_oe);
    check({7'h0, rd_oe}, {7'h0, !m_lat});
    if (!m_lat && mem[a] >= 0)
      check(rd_d, 8'(mem[a]));
  endtask

  // bench counts out the cycle: busy read just before its end, irq checked two edges on
  // Kind 0 plain, 1 mode clear tried mid-cycle, 2 wait entry mid-cycle
  task automatic prog(input int kind);
    cpu.wr(CSR, {5'h00, m_ie, 2'b11});
    m_lat = 1'b1;
    if (kind == 1)
      cpu.wr(CSR, {5'h00, m_ie, 2'b01});
    if (kind == 2)
    begin
      cpu.pulse(4'h4);
      check({7'h0, wait_mode}, 8'h00);
    end
    // Each mid-cycle access costs two edges
    repeat (kind != 0 ? PC - 5 : PC - 3) @(posedge clock);
    chk_csr({5'h00, m_ie, 2'b11});
    repeat (2) @(posedge clock);
    #1;
    check({7'h0, irq}, {7'h0, m_ie});
    // every latched byte lands in the row
    for (int c = 0; c < 16; c++)
      if (latv[c] >= 0)
        mem[row * 16 + c] = latv[c];
    latv = '{default: -1};
    m_lat = 1'b0;
    chk_csr({5'h00, m_ie, 2'b00});
    check({7'h0, wait_mode}, {7'h0, kind == 2});
    if (kind == 2)
      cpu.pulse(4'h1);
  endtask

  task automatic done(input string s);
    $display("Test %s finished", s);
  endtask

  // Main sequence
  initial
  begin
    rst = 1'b1;
    {m_ie, m_lat, row} = '0;
    repeat (16) @(posedge clock);
    #1;
    rst = 1'b0;
    chk_csr(8'h00);
    csr_wr(8'hF4);
    chk_csr(8'h04);
    cpu.rd(16'h002D, rd_d, rd_oe);
    check({7'h0, rd_oe}, 8'h00);
    done("register");
    // all writes of a cycle stay in one row
    csr_wr(8'h02);
    for (int c = 0; c < 16; c++)
      aw({4'h5, 4'(c)}, rnd());
    prog(0);
    for (int c = 0; c < 16; c++)
      chk_arr({4'h5, 4'(c)});
    aw(8'h53, 8'(~mem[8'h53]));
    chk_arr(8'h53);
    done("row");
    csr_wr(8'h06);
    aw(8'h52, 8'h00);
    chk_arr(8'h52);
    csr_wr(8'h04);
    csr_wr(8'h06);
    aw(8'h50, rnd());
    aw(8'h50, rnd());
    aw(8'h51, rnd());
    prog(1);
    for (int c = 0; c < 3; c++)
      chk_arr(8'h50 + 8'(c));
    cpu.pulse(4'h8);
    @(posedge clock);
    #1;
    check({7'h0, irq}, 8'h00);
    done("merge");
    cpu.pulse(4'h4);
    check({7'h0, wait_mode}, 8'h01);
    cpu.pulse(4'h1);
    check({7'h0, wait_mode}, 8'h00);
    csr_wr(8'h02);
    aw(8'h54, rnd());
    prog(2);
    chk_arr(8'h54);
    done("wait");
    // the halt event breaks into the running cycle
    csr_wr(8'h02);
    aw(8'h57, 8'(~mem[8'h57]));
    cpu.wr(CSR, 8'h03);
    cpu.pulse(4'h2);
    check({7'h0, halt_mode}, 8'h01);
    cpu.pulse(4'h1);
    check({7'h0, halt_mode}, 8'h00);
    cpu.rd(CSR, rd_d, rd_oe);
    check({7'h0, rd_d[0]}, 8'h00);
    repeat (PC) @(posedge clock);
    csr_wr(8'h00);
    chk_arr(8'h57);
    done("halt");
    results();
  end
endmodule
`default_nettype wire
